// [rtl/i2cgc_pkg.sv]
// Functional notes
// - Writing one to control bit 4 clears the general call and matched-ID status bits, and the bit always reads back as zero.
// - With control bits 3 and 2 both set, the byte after a general call address is compared with the alternate ID, and a match is a hardware general call.
// - With the hardware general call enable clear, hardware general calls are never recognised.
// - With general call enabled, the slave acknowledges address 0x00 with the write direction and takes the next byte as a command.
// - With general call enabled, command byte 0x06 resets the slave interface.
// - With general call enabled, a general call such as command 0x04 sets the general call status bit, and software then reprograms the slave address.
// - With general call disabled, general call addresses and commands are neither acknowledged nor acted on.
// - Control bit 1 selects 10-bit address decoding when one and 7-bit decoding when zero.
// - Control bit 0 enables slave mode when set and disables it when cleared.
// - The two-bit matched-ID field reports which of the four ID registers matched, coded 00 to 11.
package i2cgc_pkg;

  // Control register layout
  localparam int CTRL_SLAVE_EN_BIT = 0;
  localparam int CTRL_TEN_BIT_BIT = 1;
  localparam int CTRL_GC_EN_BIT = 2;
  localparam int CTRL_HW_GC_EN_BIT = 3;
  localparam int CTRL_GC_CLR_BIT = 4;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // Bus codes
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [7:0] GC_CMD_RESET = 8'h06;
  localparam logic [7:0] GC_CMD_PROG = 8'h04;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int NUM_IDS = 4;

  typedef logic [NUM_IDS-1:0][9:0] i2cgc_ids_t;

  typedef struct packed {
    logic hw_gencall_enable;
    logic gencall_enable;
    logic ten_bit_address_enable;
    logic slave_mode_enable;
  } i2cgc_ctrl_t;

  typedef struct packed {
    logic busy;                 // Start plus own address seen
    logic rep_start;            // Repeated start while busy
    logic stop_det;             // Stop after start and match
    logic gencall;              // General call status
    logic gencall_hw;           // Hardware general call seen
    logic [1:0] matched_id_field;
  } i2cgc_status_t;

  localparam i2cgc_status_t STATUS_RESET = '0;

endpackage : i2cgc_pkg

// [rtl/i2cgc_slave.sv]
`timescale 1ns/1ns
`default_nettype none
module i2cgc_slave (
  input wire logic clk,                          // 100 MHz system clock
  input wire logic reset_n,                      // Sync reset, active low
  input wire logic scl_i,                        // SCL pin level
  input wire logic sda_i,                        // SDA pin level
  output logic sda_o,                            // SDA drive value
  output logic sda_oe,                           // SDA pull low enable
  input wire logic ctrl_wr,                      // Control write strobe
  input wire logic [15:0] ctrl_wdata,            // Control write data
  output logic [15:0] ctrl_rdata,                // Control read data
  input wire logic [7:0] alternate_id,           // Alternate ID register
  input wire i2cgc_pkg::i2cgc_ids_t slave_ids,   // Four slave ID registers
  output i2cgc_pkg::i2cgc_status_t slave_status, // Slave status flags
  output logic [7:0] rx_data,                    // Last received data byte
  output logic rx_valid                          // Data byte pulse
);
  import i2cgc_pkg::*;

  typedef enum logic [2:0] {IDLE, ADDR, ADDR2, DATA, ACK, SKIP} i2cgc_state_t;

  logic scl_s, sda_s;
  logic scl_prev_r, sda_prev_r;
  logic scl_rise, scl_fall, start_det, stop_det;
  i2cgc_ctrl_t ctrl_r, ctrl_nxt;
  logic gc_clr;
  i2cgc_state_t state_r, state_nxt, after_r, after_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [1:0] hi_r, hi_nxt;
  logic gc_mode_r, gc_mode_nxt;
  logic sda_oe_r, sda_oe_nxt;
  i2cgc_status_t st_r, st_nxt;
  logic [7:0] rx_data_r, rx_data_nxt;
  logic rx_valid_r, rx_valid_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic decide;
  logic set_gc, set_hw, set_id;
  logic [1:0] set_idx;
  logic [2:0] m7, m10;

  // Returns {hit, index} of the lowest ID that matches the address
  function automatic logic [2:0] id_match(input i2cgc_ids_t ids,
      input logic [9:0] addr, input logic ten);
    logic [2:0] res;
    res = 3'h0;
    for (int i = NUM_IDS - 1; i >= 0; i--) begin
      if (ten ? (ids[i] == addr) : (ids[i][6:0] == addr[6:0])) begin
        res = {1'b1, 2'(i)};
      end
    end
    return res;
  endfunction : id_match

  i2cgc_sync #(.WIDTH(2)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d({scl_i, sda_i}),
    .q({scl_s, sda_s})
  );

  // Bus events from the synchronised lines
  assign scl_rise = scl_s & ~scl_prev_r;
  assign scl_fall = ~scl_s & scl_prev_r;
  assign start_det = scl_s & scl_prev_r & sda_prev_r & ~sda_s;
  assign stop_det = scl_s & scl_prev_r & ~sda_prev_r & sda_s;
  assign decide = scl_fall && cnt_r == BITS_PER_BYTE &&
                  (state_r == ADDR || state_r == ADDR2 || state_r == DATA);
  assign m7 = id_match(slave_ids, {3'h0, shift_r[7:1]}, 1'b0);
  assign m10 = id_match(slave_ids, {hi_r, shift_r}, 1'b1);
  assign gc_clr = ctrl_wr & ctrl_wdata[CTRL_GC_CLR_BIT];

  // Control register; the clear bit is a strobe, never stored
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (ctrl_wr) begin
      ctrl_nxt.slave_mode_enable = ctrl_wdata[CTRL_SLAVE_EN_BIT];
      ctrl_nxt.ten_bit_address_enable = ctrl_wdata[CTRL_TEN_BIT_BIT];
      ctrl_nxt.gencall_enable = ctrl_wdata[CTRL_GC_EN_BIT];
      ctrl_nxt.hw_gencall_enable = ctrl_wdata[CTRL_HW_GC_EN_BIT];
    end
    rdata_nxt = 16'h0000;
    rdata_nxt[CTRL_SLAVE_EN_BIT] = ctrl_nxt.slave_mode_enable;
    rdata_nxt[CTRL_TEN_BIT_BIT] = ctrl_nxt.ten_bit_address_enable;
    rdata_nxt[CTRL_GC_EN_BIT] = ctrl_nxt.gencall_enable;
    rdata_nxt[CTRL_HW_GC_EN_BIT] = ctrl_nxt.hw_gencall_enable;
  end

  // Protocol engine: samples on SCL rise, drives ACK after SCL fall
  always_comb begin
    state_nxt = state_r;
    after_nxt = after_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    hi_nxt = hi_r;
    gc_mode_nxt = gc_mode_r;
    sda_oe_nxt = sda_oe_r;
    st_nxt = st_r;
    rx_data_nxt = rx_data_r;
    rx_valid_nxt = 1'b0;
    set_gc = 1'b0;
    set_hw = 1'b0;
    set_id = 1'b0;
    set_idx = 2'h0;
    if (!ctrl_r.slave_mode_enable) begin
      // Disabled: bus released, flags kept unless a software clear is written
      state_nxt = IDLE;
      sda_oe_nxt = 1'b0;
    end else if (start_det) begin
      if (st_r.busy) begin
        st_nxt.rep_start = 1'b1;
      end
      state_nxt = ADDR;
      cnt_nxt = 4'h0;
      gc_mode_nxt = 1'b0;
      sda_oe_nxt = 1'b0;
    end else if (stop_det) begin
      if (st_r.busy) begin
        st_nxt.stop_det = 1'b1;
      end
      st_nxt.busy = 1'b0;
      st_nxt.rep_start = 1'b0;
      state_nxt = IDLE;
      sda_oe_nxt = 1'b0;
    end else if (decide) begin
      state_nxt = ACK;
      sda_oe_nxt = 1'b1;
      after_nxt = DATA;
      case (state_r)
        ADDR: begin
          if (shift_r == GC_ADDR && ctrl_r.gencall_enable) begin
            gc_mode_nxt = 1'b1;
            st_nxt.busy = 1'b1;
            set_gc = 1'b1;
          end else if (shift_r == GC_ADDR) begin
            state_nxt = SKIP;
            sda_oe_nxt = 1'b0;
          end else if (ctrl_r.ten_bit_address_enable) begin
            // First byte of a 10-bit address carries the top two bits
            hi_nxt = shift_r[2:1];
            after_nxt = ADDR2;
            if (shift_r[7:3] != TEN_BIT_PREFIX || shift_r[0]) begin
              state_nxt = SKIP;
              sda_oe_nxt = 1'b0;
            end
          end else if (m7[2] && !shift_r[0]) begin
            st_nxt.busy = 1'b1;
            set_id = 1'b1;
            set_idx = m7[1:0];
          end else begin
            state_nxt = SKIP;
            sda_oe_nxt = 1'b0;
          end
        end
        ADDR2: begin
          if (m10[2]) begin
            st_nxt.busy = 1'b1;
            set_id = 1'b1;
            set_idx = m10[1:0];
          end else begin
            state_nxt = SKIP;
            sda_oe_nxt = 1'b0;
          end
        end
        default: begin
          rx_data_nxt = shift_r;
          rx_valid_nxt = 1'b1;
          if (gc_mode_r) begin
            gc_mode_nxt = 1'b0;
            if (ctrl_r.hw_gencall_enable && ctrl_r.gencall_enable &&
                shift_r == alternate_id) begin
              set_hw = 1'b1;
            end else if (shift_r == GC_CMD_RESET) begin
              // Interface reset: drop the transfer after this ACK
              after_nxt = IDLE;
              st_nxt.busy = 1'b0;
              st_nxt.rep_start = 1'b0;
              st_nxt.stop_det = 1'b0;
            end else if (shift_r == GC_CMD_PROG) begin
              set_gc = 1'b1;
            end
          end
        end
      endcase
    end else if (scl_fall && state_r == ACK) begin
      sda_oe_nxt = 1'b0;
      cnt_nxt = 4'h0;
      state_nxt = after_r;
    end else if (scl_rise && state_r != IDLE && state_r != ACK) begin
      shift_nxt = {shift_r[6:0], sda_s};
      cnt_nxt = (cnt_r == BITS_PER_BYTE) ? 4'h1 : 4'(cnt_r + 4'h1);
    end
    // Software clear loses against a set in the same cycle
    if (gc_clr) begin
      st_nxt.gencall = 1'b0;
      st_nxt.gencall_hw = 1'b0;
      st_nxt.matched_id_field = 2'h0;
    end
    if (set_gc) begin
      st_nxt.gencall = 1'b1;
    end
    if (set_hw) begin
      st_nxt.gencall = 1'b1;
      st_nxt.gencall_hw = 1'b1;
    end
    if (set_id) begin
      st_nxt.matched_id_field = set_idx;
    end
  end

  // Register stage for all state
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
      ctrl_r <= i2cgc_ctrl_t'(CTRL_RESET[3:0]);
      rdata_r <= CTRL_RESET;
      state_r <= IDLE;
      after_r <= IDLE;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      hi_r <= 2'h0;
      gc_mode_r <= 1'b0;
      sda_oe_r <= 1'b0;
      st_r <= STATUS_RESET;
      rx_data_r <= 8'h00;
      rx_valid_r <= 1'b0;
    end else begin
      scl_prev_r <= scl_s;
      sda_prev_r <= sda_s;
      ctrl_r <= ctrl_nxt;
      rdata_r <= rdata_nxt;
      state_r <= state_nxt;
      after_r <= after_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      hi_r <= hi_nxt;
      gc_mode_r <= gc_mode_nxt;
      sda_oe_r <= sda_oe_nxt;
      st_r <= st_nxt;
      rx_data_r <= rx_data_nxt;
      rx_valid_r <= rx_valid_nxt;
    end
  end

  // Open drain: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe = sda_oe_r;
  assign ctrl_rdata = rdata_r;
  assign slave_status = st_r;
  assign rx_data = rx_data_r;
  assign rx_valid = rx_valid_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Clear bit never reads back, clear takes effect next cycle
  clr_reads_zero_a: assert property (ctrl_rdata[CTRL_GC_CLR_BIT] == 1'b0)
    else $error("clear bit read back as one");
  gc_clear_a: assert property (gc_clr && !set_gc && !set_hw |=>
      !st_r.gencall && !st_r.gencall_hw && st_r.matched_id_field == 2'h0)
    else $error("general call status not cleared");
  hw_gc_match_a: assert property (decide && state_r == DATA && gc_mode_r &&
      ctrl_r.slave_mode_enable &&
      ctrl_r.hw_gencall_enable && ctrl_r.gencall_enable &&
      shift_r == alternate_id |=> st_r.gencall_hw && sda_oe_r)
    else $error("hardware general call missed");
  hw_gc_off_a: assert property ($rose(st_r.gencall_hw) |->
      $past(ctrl_r.hw_gencall_enable) && $past(ctrl_r.gencall_enable))
    else $error("hardware general call while disabled");
  gc_ack_a: assert property (decide && state_r == ADDR &&
      shift_r == GC_ADDR && ctrl_r.gencall_enable && ctrl_r.slave_mode_enable
      |=> sda_oe_r && state_r == ACK && after_r == DATA && gc_mode_r)
    else $error("general call address not acknowledged");
  gc_reset_a: assert property (decide && state_r == DATA && gc_mode_r &&
      !ctrl_r.hw_gencall_enable && shift_r == GC_CMD_RESET &&
      ctrl_r.slave_mode_enable |=> after_r == IDLE && !st_r.busy)
    else $error("reset command did not reset interface");
  gc_flag_a: assert property ($rose(st_r.gencall) |->
      $past(ctrl_r.gencall_enable))
    else $error("general call flag set while disabled");
  gc_nack_a: assert property (decide && state_r == ADDR &&
      shift_r == GC_ADDR && !ctrl_r.gencall_enable |=> !sda_oe_r [*2])
    else $error("general call acknowledged while disabled");
  ten_bit_a: assert property (decide && state_r == ADDR &&
      ctrl_r.ten_bit_address_enable && shift_r != GC_ADDR &&
      shift_r[7:3] != TEN_BIT_PREFIX |=> !sda_oe_r && state_r != ACK)
    else $error("bad 10-bit prefix acknowledged");
  id_field_a: assert property (decide && state_r == ADDR &&
      ctrl_r.slave_mode_enable && !ctrl_r.ten_bit_address_enable &&
      shift_r != GC_ADDR && m7[2] && !shift_r[0]
      |=> st_r.matched_id_field == $past(m7[1:0]))
    else $error("matched ID field wrong");
  disabled_quiet_a: assert property (!ctrl_r.slave_mode_enable
      |=> !sda_oe_r && state_r == IDLE && (st_r == $past(st_r) || $past(gc_clr)))
    else $error("disabled slave active");

  gc_reset_c: cover property (decide && gc_mode_r && shift_r == GC_CMD_RESET);
  hw_gc_c: cover property ($rose(st_r.gencall_hw));
  ten_bit_c: cover property (decide && state_r == ADDR2 && m10[2]);
  data_byte_c: cover property (rx_valid_r && !gc_mode_r);
endmodule : i2cgc_slave
`default_nettype wire

// [rtl/i2cgc_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module i2cgc_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk,               // System clock
  input wire logic reset_n,           // Synchronous reset, active low
  input wire logic [WIDTH-1:0] d,     // Asynchronous pin levels
  output logic [WIDTH-1:0] q          // Synchronised levels
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] q_r;
  logic [WIDTH-1:0] q_nxt;

  // Released bus lines idle high, so reset to ones
  always_comb begin
    meta_nxt = d;
    q_nxt = meta_r;
  end

  // Two stages; only the second stage is seen outside
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta_r <= '1;
      q_r <= '1;
    end else begin
      meta_r <= meta_nxt;
      q_r <= q_nxt;
    end
  end

  assign q = q_r;
endmodule : i2cgc_sync
`default_nettype wire

// [test/i2cgc_master_model.sv]
`timescale 1ns/1ns
`default_nettype none
// Behavioural bus master; SCL stands high and SDA is released between frames
module i2cgc_master_model (
  output logic scl, // SCL level from the master
  output logic sda_oe, // High pulls SDA low
  input wire logic sda // Resolved SDA level
);
  int q = 31; // Quarter bit time in ns, raised for a slow master
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // SDA falls while SCL is high; also serves as a repeated start
  task automatic start_cond();
    sda_oe = 1'b0;
    #q scl = 1'b1;
    #q sda_oe = 1'b1;
    #q scl = 1'b0;
    #q;
  endtask : start_cond
  // SDA moves mid-low so it is steady around both SCL edges
  task automatic put_bit(input logic b, output logic got);
    sda_oe = !b;
    #q scl = 1'b1;
    #q got = sda;
    #q scl = 1'b0;
    #q;
  endtask : put_bit
  // Byte sent MSB first, then SDA released for the acknowledge bit
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic d;
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i], d);
    end
    put_bit(1'b1, d);
    ack = !d;
  endtask : put_byte
  // SDA rises while SCL is high, then both lines stay released
  task automatic stop_cond();
    sda_oe = 1'b1;
    #q scl = 1'b1;
    #q sda_oe = 1'b0;
    #q;
  endtask : stop_cond
endmodule : i2cgc_master_model
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb;
  import i2cgc_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic ctrl_wr = 1'b0;
  logic [15:0] ctrl_wdata = 16'h0000;
  logic [7:0] alternate_id = 8'h01;
  i2cgc_ids_t slave_ids = '0;
  wire logic scl;
  wire logic m_oe;
  wire logic sda;
  logic sda_o, sda_oe, rx_valid, ack;
  logic [15:0] ctrl_rdata, w;
  logic [7:0] rx_data, d;
  i2cgc_status_t slave_status;
  logic [6:0] base;
  logic [9:0] a10;
  int err_count = 0;
  int checks_done = 0;
  int k;
  // Open-drain SDA with a pull-up: low if anyone pulls
  assign sda = (m_oe || sda_oe) ? 1'b0 : 1'b1;
  always #5 clk = ~clk;
  i2cgc_slave u_i2cgc_slave (.clk(clk), .reset_n(reset_n), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata),
    .alternate_id(alternate_id), .slave_ids(slave_ids),
    .slave_status(slave_status), .rx_data(rx_data), .rx_valid(rx_valid));
  i2cgc_master_model u_i2cgc_master_model (.scl(scl), .sda_oe(m_oe),
    .sda(sda));
  // Value and acknowledge comparisons
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_ack(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t ack got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_ack
  // Expected status word and control readback
  function automatic logic [15:0] exp_st(input logic [2:0] fl,
    input logic gc, input logic hw, input logic [1:0] id);
    return {9'h000, fl, gc, hw, id};
  endfunction : exp_st
  function automatic logic [15:0] exp_ctrl(input logic [15:0] v);
    return {12'h000, v[3:0]};
  endfunction : exp_ctrl
  task automatic do_reset();
    reset_n = 1'b0;
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask : do_reset
  // One-cycle write strobe, applied on the falling edge
  task automatic wr(input logic [15:0] v);
    @(negedge clk);
    ctrl_wr = 1'b1;
    ctrl_wdata = v;
    @(negedge clk);
    ctrl_wr = 1'b0;
    @(negedge clk);
  endtask : wr
  task automatic sb(input logic [7:0] b, input logic exp);
    u_i2cgc_master_model.put_byte(b, ack);
    chk_ack(ack, exp);
  endtask : sb
  // Stop, then let the synchroniser catch up before looking at flags
  task automatic fin();
    u_i2cgc_master_model.stop_cond();
    repeat (10) @(negedge clk);
  endtask : fin
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  // Watchdog, well above the expected run of about 40 us
  initial begin
    #500000;
    err_count++;
    $display("watchdog expired");
    test_done();
  end
  initial begin
    k = $urandom(13425);
    do_reset();
    chk_val(ctrl_rdata, 16'h0000);
    chk_val({15'h0000, sda_o}, 16'h0000);
    chk_val(16'(slave_status), 16'h0000);
    // Random control words; the clear bit must never read back
    repeat (4) begin
      w = 16'($urandom) | 16'h0010;
      wr(w);
      chk_val(ctrl_rdata, exp_ctrl(w));
    end
    $display("test control readback done");
    // 7-bit match, data byte, stop, then disabled slave ignores the bus
    for (int n = 0; n < 3; n++) begin
      do_reset();
      base = 7'h08 + 7'($urandom_range(0, 100));
      for (int i = 0; i < 4; i++) begin
        slave_ids[i] = {3'b000, base + 7'(i)};
      end
      k = 1 + $urandom_range(0, 2);
      d = 8'($urandom);
      wr(16'h0001);
      u_i2cgc_master_model.start_cond();
      sb({base + 7'(k), 1'b0}, 1'b1);
      chk_val(16'(slave_status), exp_st(3'b100, 1'b0, 1'b0, 2'(k)));
      sb(d, 1'b1);
      chk_val({8'h00, rx_data}, {8'h00, d});
      // Repeated start while busy, same address again
      u_i2cgc_master_model.start_cond();
      sb({base + 7'(k), 1'b0}, 1'b1);
      chk_val(16'(slave_status), exp_st(3'b110, 1'b0, 1'b0, 2'(k)));
      fin();
      chk_val(16'(slave_status), exp_st(3'b001, 1'b0, 1'b0, 2'(k)));
      wr(16'h0000);
      u_i2cgc_master_model.start_cond();
      sb({base, 1'b0}, 1'b0);
      fin();
      chk_val(16'(slave_status), exp_st(3'b001, 1'b0, 1'b0, 2'(k)));
      wr(16'h0010);
      chk_val(16'(slave_status), exp_st(3'b001, 1'b0, 1'b0, 2'b00));
      u_i2cgc_master_model.q = 40;
    end
    u_i2cgc_master_model.q = 31;
    $display("test seven bit done");
    // Ten-bit address; same first byte is refused in 7-bit mode
    do_reset();
    a10 = (10'($urandom) & 10'h3BF) | 10'h004;
    k = $urandom_range(0, 3);
    for (int i = 0; i < 4; i++) begin
      slave_ids[i] = {a10[9:2], 2'(i)};
    end
    wr(16'h0003);
    u_i2cgc_master_model.start_cond();
    sb({TEN_BIT_PREFIX, a10[9:8], 1'b0}, 1'b1);
    sb({a10[7:2], 2'(k)}, 1'b1);
    chk_val(16'(slave_status), exp_st(3'b100, 1'b0, 1'b0, 2'(k)));
    fin();
    wr(16'h0001);
    u_i2cgc_master_model.start_cond();
    sb({TEN_BIT_PREFIX, a10[9:8], 1'b0}, 1'b0);
    fin();
    $display("test ten bit done");
    // General call refused while disabled
    do_reset();
    wr(16'h0001);
    u_i2cgc_master_model.start_cond();
    sb(GC_ADDR, 1'b0);
    fin();
    chk_val(16'(slave_status), 16'h0000);
    // Both general call commands, then a write-one clear
    for (int j = 0; j < 2; j++) begin
      do_reset();
      wr(16'h0005);
      u_i2cgc_master_model.start_cond();
      sb(GC_ADDR, 1'b1);
      chk_val(16'(slave_status), exp_st(3'b100, 1'b1, 1'b0, 2'b00));
      sb(j ? GC_CMD_RESET : GC_CMD_PROG, 1'b1);
      if (j == 1) begin
        chk_val({15'h0000, slave_status.busy}, 16'h0000);
        sb(8'hA5, 1'b0);
      end
      fin();
      chk_val({14'h0000, slave_status.gencall, slave_status.gencall_hw},
        16'h0002);
      wr(16'h0015);
      chk_val(ctrl_rdata, 16'h0005);
      chk_val({14'h0000, slave_status.gencall, slave_status.gencall_hw},
        16'h0000);
    end
    $display("test general call done");
    // Alternate ID match counts only with the hardware enable set
    for (int j = 0; j < 2; j++) begin
      do_reset();
      alternate_id = {7'($urandom), 1'b1};
      wr(j ? 16'h000D : 16'h0005);
      u_i2cgc_master_model.start_cond();
      sb(GC_ADDR, 1'b1);
      sb(alternate_id, 1'b1);
      fin();
      chk_val({15'h0000, slave_status.gencall_hw}, 16'(j));
    end
    $display("test hardware general call done");
    test_done();
  end
endmodule : tb
`default_nettype wire
